// >>> verilog/ltdb_top.sv
// ltdb_top: transmit descriptor engine, dual fifos, shared memory master
// and interframe counter of an ethernet controller
// assumes memory holds ack high one cycle per request; rx bytes and
// rx_sof_i come from logic on ref_clk_i; rx_crs_i is an asynchronous pin
//
// Functional notes
// [R1] separate 48-byte transmit fifo and 64-byte receive fifo
// [R2] receive frame start requests a poll of the pending transmit descriptor
// [R3] owned descriptor: tx fill reads alternate with rx drain writes
// [R4] loaded frame leaves as soon as the interframe gap after receive ends
// [R5] fcs flag clear: every frame gets fcs, descriptor bit ignored
// [R6] fcs flag set: fcs only when descriptor word1 bit 13 is one
// [R7] per-packet fcs bit is read only from the start-of-packet descriptor
// [R8] status writeback keeps word1 bit 13 as read
// [R9] modified backoff enable selects the modified backoff behaviour
// [R10] modified backoff: interframe counter holds during carrier sense
// [R11] software enables modified backoff only where all nodes use it
// [R12] byte count is two's complement, incremented per byte, done at zero
// [R13] all 16 bits of word2 form the byte count
// [R14] zero count: clear ownership at once, no transmit
// [R15] software sets word2 upper four bits to ones for compatibility
// [R16] start-of-packet fcs decision covers the whole chained frame
`timescale 1ns/1ps

// ltdb_fifo: synchronous fifo, depth need not be a power of two
module ltdb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 in_valid_i,
  input  wire logic [W-1:0]         in_data_i,
  output logic                      in_ready_o,
  output logic                      out_valid_o,
  output logic [W-1:0]              out_data_o,
  input  wire logic                 out_ready_i,
  output logic [$clog2(D+1)-1:0]    count_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          push;
  logic          pop;

  // handshakes from the fill level
  assign in_ready_o  = (cnt_r != CW'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign count_o     = cnt_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // pointers wrap at depth, count tracks fill
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule : ltdb_fifo

module ltdb_top (
  input  wire logic                           ref_clk_i,
  input  wire logic                           resetn_i,
  input  wire logic                           disable_tx_fcs_flag_i,
  input  wire logic                           modified_backoff_enable_i,
  input  wire logic                           tx_demand_i,
  input  wire logic [ltdb_pkg::ADDR_W-1:0]    tx_desc_addr_i,
  input  wire logic [ltdb_pkg::ADDR_W-1:0]    rx_buf_addr_i,
  input  wire logic                           rx_sof_i,
  input  wire logic                           rx_crs_i,
  input  wire logic                           rx_valid_i,
  input  wire logic [ltdb_pkg::BYTE_W-1:0]    rx_data_i,
  output logic                                rx_ready_o,
  output logic                                mem_req_o,
  output logic                                mem_we_o,
  output logic [ltdb_pkg::ADDR_W-1:0]         mem_addr_o,
  output logic [1:0]                          mem_be_o,
  output logic [ltdb_pkg::DATA_W-1:0]         mem_wdata_o,
  input  wire logic [ltdb_pkg::DATA_W-1:0]    mem_rdata_i,
  input  wire logic                           mem_ack_i,
  output logic                                tx_valid_o,
  output logic [ltdb_pkg::BYTE_W-1:0]         tx_data_o,
  output logic                                tx_last_o,
  output logic                                tx_fcs_o,
  input  wire logic                           tx_ready_i,
  output logic                                tx_engine_busy_o
);
  import ltdb_pkg::*;

  ltdb_state_type    state_r;
  logic [ADDR_W-1:0] cur_addr_r;
  logic [ADDR_W-1:0] buf_addr_r;
  logic [DATA_W-1:0] w1_r;
  logic [DATA_W-1:0] cnt_r;
  logic [DATA_W-1:0] cnt_inc;
  logic              zero_r;
  logic              fcs_r;
  logic              poll_r;
  logic              busy_r;
  logic              own_tx_r;
  logic              last_tx_r;
  logic [ADDR_W-1:0] rx_addr_r;
  logic              tx_ack;
  logic              tx_need;
  logic              gnt_tx;
  logic              gnt_rx;
  logic [ADDR_W-1:0] tx_addr;
  logic              tx_we;
  logic [DATA_W-1:0] tx_wd;
  logic [BYTE_W-1:0] rd_byte;
  logic              txf_in_ready;
  logic              txf_valid;
  logic [TXF_W-1:0]  txf_data;
  logic              txf_pop;
  logic [5:0]        txf_count;
  logic              rxf_valid;
  logic [BYTE_W-1:0] rxf_data;
  logic              crs_m1_r;
  logic              crs_m2_r;
  logic              crs_m3_r;
  logic              crs_s_r;
  logic [IFS_W-1:0]  ifs_cnt_r;
  logic              ifs_done;
  logic              line_busy_r;

  // [R1] transmit fifo
  // [R16] bytes carry frame fcs
  ltdb_fifo #(.W(TXF_W), .D(TXF_DEPTH)) u_txf (
    .clk_i       (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (tx_ack && (state_r == ST_DATA)),
    .in_data_i   ({(cnt_inc == CNT_RST) && w1_r[ENP_BIT], fcs_r, rd_byte}),
    .in_ready_o  (txf_in_ready),
    .out_valid_o (txf_valid),
    .out_data_o  (txf_data),
    .out_ready_i (txf_pop),
    .count_o     (txf_count)
  );

  // [R1] receive fifo
  ltdb_fifo #(.W(BYTE_W), .D(RXF_DEPTH)) u_rxf (
    .clk_i       (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (rx_valid_i),
    .in_data_i   (rx_data_i),
    .in_ready_o  (rx_ready_o),
    .out_valid_o (rxf_valid),
    .out_data_o  (rxf_data),
    .out_ready_i (gnt_rx),
    .count_o     ()
  );

  // byte lane of the buffer word and the incremented count
  assign rd_byte = buf_addr_r[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
  assign cnt_inc = cnt_r + CNT_ONE;
  assign tx_ack  = mem_ack_i && busy_r && own_tx_r;

  // memory request of the descriptor engine
  always_comb begin
    tx_need = 1'b0;
    tx_addr = cur_addr_r + OFS_W1;
    tx_we   = 1'b0;
    // [R8] writeback keeps bit 13
    tx_wd   = {1'b0, w1_r[OWN_BIT-1:0]};
    unique case (state_r)
      ST_IDLE: tx_need = 1'b0;
      ST_W1:   tx_need = 1'b1;
      ST_W0: begin
        tx_need = 1'b1;
        tx_addr = cur_addr_r + OFS_W0;
      end
      ST_W2: begin
        tx_need = 1'b1;
        tx_addr = cur_addr_r + OFS_W2;
      end
      ST_DATA: begin
        tx_need = txf_in_ready;
        tx_addr = buf_addr_r;
      end
      ST_WB: begin
        tx_need = 1'b1;
        tx_we   = 1'b1;
      end
    endcase
  end

  // [R3] alternate grants when both streams want the bus
  assign gnt_tx = !busy_r && tx_need && (!rxf_valid || !last_tx_r);
  assign gnt_rx = !busy_r && rxf_valid && !gnt_tx;

  // memory master: one request outstanding, held until ack
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      busy_r      <= 1'b0;
      own_tx_r    <= 1'b0;
      last_tx_r   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= '0;
      mem_be_o    <= 2'b00;
      mem_wdata_o <= '0;
    end else if (gnt_tx) begin
      busy_r      <= 1'b1;
      own_tx_r    <= 1'b1;
      last_tx_r   <= 1'b1;
      mem_we_o    <= tx_we;
      mem_addr_o  <= tx_addr;
      mem_be_o    <= 2'b11;
      mem_wdata_o <= tx_wd;
    end else if (gnt_rx) begin
      busy_r      <= 1'b1;
      own_tx_r    <= 1'b0;
      last_tx_r   <= 1'b0;
      mem_we_o    <= 1'b1;
      mem_addr_o  <= rx_addr_r;
      mem_be_o    <= rx_addr_r[0] ? 2'b10 : 2'b01;
      mem_wdata_o <= {rxf_data, rxf_data};
    end else if (mem_ack_i) begin
      busy_r <= 1'b0;
    end
  end
  assign mem_req_o = busy_r;

  // receive drain pointer, reloaded at each frame start
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rx_addr_r <= '0;
    end else if (rx_sof_i) begin
      rx_addr_r <= rx_buf_addr_i;
    end else if (gnt_rx) begin
      rx_addr_r <= rx_addr_r + 24'h00_0001;
    end
  end

  // [R2] poll request on receive start or demand; set beats clear
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      poll_r <= 1'b0;
    end else if (rx_sof_i || tx_demand_i) begin
      poll_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      poll_r <= 1'b0;
    end
  end

  // descriptor engine sequence
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r    <= ST_IDLE;
      cur_addr_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (poll_r) begin
            state_r    <= ST_W1;
            cur_addr_r <= tx_desc_addr_i;
          end
        end
        ST_W1:   if (tx_ack) state_r <= mem_rdata_i[OWN_BIT] ? ST_W0 : ST_IDLE;
        ST_W0:   if (tx_ack) state_r <= ST_W2;
        // [R14] zero count skips all data reads
        ST_W2:   if (tx_ack) state_r <= (mem_rdata_i == CNT_RST) ? ST_WB : ST_DATA;
        ST_DATA: if (tx_ack && (cnt_inc == CNT_RST)) state_r <= ST_WB;
        ST_WB: begin
          if (tx_ack) begin
            state_r    <= w1_r[ENP_BIT] ? ST_IDLE : ST_W1;
            cur_addr_r <= cur_addr_r + DESC_STRIDE;
          end
        end
      endcase
    end
  end

  // descriptor fields and byte count
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      w1_r       <= '0;
      buf_addr_r <= '0;
      cnt_r      <= CNT_RST;
      zero_r     <= 1'b0;
    end else if (tx_ack) begin
      if (state_r == ST_W1) w1_r <= mem_rdata_i;
      if (state_r == ST_W0) buf_addr_r <= {w1_r[HADR_W-1:0], mem_rdata_i};
      // [R13] full 16-bit count
      if (state_r == ST_W2) begin
        cnt_r  <= mem_rdata_i;
        zero_r <= (mem_rdata_i == CNT_RST);
      end
      // [R12] count up to zero
      if (state_r == ST_DATA) begin
        cnt_r      <= cnt_inc;
        buf_addr_r <= buf_addr_r + 24'h00_0001;
      end
    end
  end

  // [R5] [R6] [R7] fcs decision at start of packet only
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      fcs_r <= 1'b1;
    end else if (tx_ack && (state_r == ST_W1) && mem_rdata_i[OWN_BIT]
                 && mem_rdata_i[STP_BIT]) begin
      fcs_r <= !disable_tx_fcs_flag_i || mem_rdata_i[FCS_BIT];
    end
  end

  // carrier sense synchroniser, change taken when stages agree
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      crs_m1_r <= 1'b0;
      crs_m2_r <= 1'b0;
      crs_m3_r <= 1'b0;
      crs_s_r  <= 1'b0;
    end else begin
      crs_m1_r <= rx_crs_i;
      crs_m2_r <= crs_m1_r;
      crs_m3_r <= crs_m2_r;
      if (crs_m2_r == crs_m3_r) crs_s_r <= crs_m3_r;
    end
  end

  // [R9] [R10] interframe counter: restart or hold on carrier
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ifs_cnt_r <= IFS_RST;
    end else if (crs_s_r) begin
      if (!modified_backoff_enable_i) ifs_cnt_r <= IFS_RST;
    end else if (ifs_cnt_r != IFS_CYC_V) begin
      ifs_cnt_r <= ifs_cnt_r + 11'h001;
    end
  end
  assign ifs_done = (ifs_cnt_r == IFS_CYC_V);

  // [R4] frame starts once the gap expires, then runs to its last byte
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      line_busy_r <= 1'b0;
    end else if (txf_pop) begin
      line_busy_r <= !txf_data[TXF_W-1];
    end
  end
  assign tx_valid_o = txf_valid && (ifs_done || line_busy_r);
  assign txf_pop    = tx_valid_o && tx_ready_i;
  assign tx_data_o  = txf_data[BYTE_W-1:0];
  assign tx_fcs_o   = txf_data[BYTE_W];
  assign tx_last_o  = txf_data[TXF_W-1];
  assign tx_engine_busy_o = (state_r != ST_IDLE);

  a_txf_depth_cap: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R1]
    txf_count <= 6'd48) else $error("tx fifo over depth");
  a_poll_takes_w1: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R2]
    (poll_r && state_r == ST_IDLE) |=> (state_r == ST_W1)) else $error("poll lost");
  a_bus_alternate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R3]
    (!busy_r && tx_need && rxf_valid) |=> (own_tx_r != $past(last_tx_r)))
    else $error("no interleave");
  a_fcs_forced_on: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R5]
    (!disable_tx_fcs_flag_i && $stable(disable_tx_fcs_flag_i) && tx_ack
     && state_r == ST_W1 && mem_rdata_i[OWN_BIT] && mem_rdata_i[STP_BIT])
    |=> fcs_r) else $error("fcs not forced");
  a_fcs_from_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R6]
    (disable_tx_fcs_flag_i && tx_ack && state_r == ST_W1 && mem_rdata_i[OWN_BIT]
     && mem_rdata_i[STP_BIT]) |=> (fcs_r == $past(mem_rdata_i[FCS_BIT])))
    else $error("fcs bit ignored");
  a_fcs_chain_kept: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R7]
    (state_r != ST_W1 || !mem_rdata_i[STP_BIT] || !tx_ack) |=> $stable(fcs_r))
    else $error("fcs changed mid chain");
  a_wb_keeps_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R8]
    (mem_req_o && own_tx_r && mem_we_o) |-> (!mem_wdata_o[OWN_BIT]
     && mem_wdata_o[FCS_BIT] == w1_r[FCS_BIT])) else $error("writeback bit 13");
  a_ifs_std_reset: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R9]
    (crs_s_r && !modified_backoff_enable_i) |=> (ifs_cnt_r == IFS_RST))
    else $error("std counter not restarted");
  a_ifs_mod_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R10]
    (crs_s_r && modified_backoff_enable_i) |=> $stable(ifs_cnt_r))
    else $error("counter ran under carrier");
  a_count_steps: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R12]
    (tx_ack && state_r == ST_DATA) |=> (cnt_r == $past(cnt_inc)))
    else $error("byte count step");
  a_zero_no_data: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R14]
    (tx_ack && state_r == ST_W2 && mem_rdata_i == CNT_RST) |=> (state_r == ST_WB)
    ##1 (mem_req_o && mem_we_o) [*1]) else $error("zero length not skipped");
endmodule : ltdb_top

// >>> verilog/ltdb_pkg.sv
// ltdb_pkg: constants and types of the transmit descriptor and backoff block
// assumes 16-bit shared memory words, byte addressing, one 125 MHz clock
package ltdb_pkg;
  // bus and data widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int HADR_W = 8;
  // fifo depths in bytes; tx entries carry byte, fcs and last flags
  localparam int TXF_DEPTH = 48;
  localparam int RXF_DEPTH = 64;
  localparam int TXF_W     = BYTE_W + 2;
  // tx_desc_word1 field positions
  localparam int OWN_BIT = 15;
  localparam int FCS_BIT = 13;
  localparam int STP_BIT = 9;
  localparam int ENP_BIT = 8;
  // descriptor word offsets and ring stride
  localparam logic [ADDR_W-1:0] OFS_W0      = 24'h00_0000;
  localparam logic [ADDR_W-1:0] OFS_W1      = 24'h00_0002;
  localparam logic [ADDR_W-1:0] OFS_W2      = 24'h00_0004;
  localparam logic [ADDR_W-1:0] DESC_STRIDE = 24'h00_0008;
  // interframe interval, rounded up to whole cycles
  localparam int IFS_NS  = 9600;
  localparam int CLK_NS  = 8;
  localparam int IFS_CYC = (IFS_NS + CLK_NS - 1) / CLK_NS;
  localparam int IFS_W   = 11;
  localparam logic [IFS_W-1:0] IFS_CYC_V = 11'(IFS_CYC);
  localparam logic [IFS_W-1:0] IFS_RST   = 11'h000;
  // byte count reset and step
  localparam logic [DATA_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;
  // transmit descriptor engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_W1, ST_W0, ST_W2, ST_DATA, ST_WB
  } ltdb_state_type;
endpackage : ltdb_pkg

// >>> verification/ltdb_host_mem.sv
// ltdb_host_mem: host memory model answering the shared memory bus
// assumes one request at a time from the engine; slow_i stretches every answer
`timescale 1ns/1ps
module ltdb_host_mem (
  input  wire logic                        ref_clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        slow_i,
  input  wire logic                        mem_req_i,
  input  wire logic                        mem_we_i,
  input  wire logic [ltdb_pkg::ADDR_W-1:0] mem_addr_i,
  input  wire logic [1:0]                  mem_be_i,
  input  wire logic [ltdb_pkg::DATA_W-1:0] mem_wdata_i,
  output logic [ltdb_pkg::DATA_W-1:0]      mem_rdata_o,
  output logic                             mem_ack_o
);
  import ltdb_pkg::*;
  logic [DATA_W-1:0] mem_q [int];  // word store, key is byte address / 2
  int                wait_r;
  int                key;
  // read data toggles outside the ack cycle so stale values never look valid
  initial mem_rdata_o = 16'h5a5a;
  // one ack pulse per request after a short random or a long delay
  always @(posedge ref_clk_i) begin
    mem_ack_o   <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    key = int'(mem_addr_i[ADDR_W-1:1]);
    if (!resetn_i) begin
      wait_r <= -1;
    end else if (wait_r == 0) begin
      mem_ack_o <= 1'b1;
      wait_r    <= -1;
      if (!mem_q.exists(key)) mem_q[key] = 16'h0000;
      if (mem_we_i && mem_be_i[0]) mem_q[key][7:0] = mem_wdata_i[7:0];
      if (mem_we_i && mem_be_i[1]) mem_q[key][15:8] = mem_wdata_i[15:8];
      if (!mem_we_i) mem_rdata_o <= mem_q[key];
    end else if (wait_r > 0) begin
      wait_r <= wait_r - 1;
    end else if (mem_req_i && !mem_ack_o) begin
      wait_r <= slow_i ? 30 : $urandom_range(2, 0);
    end
  end
endmodule : ltdb_host_mem

// >>> verification/tb.sv
// tb: self-checking bench for the transmit descriptor and backoff block
// assumes ltdb_host_mem holds descriptors and buffers; one 125 MHz clock
`timescale 1ns/1ps
module tb;
  import ltdb_pkg::*;
  localparam logic [ADDR_W-1:0] D0  = 24'h00_1000;
  localparam logic [ADDR_W-1:0] RXA = 24'h02_0001;
  logic              ref_clk_i, resetn_i, disable_tx_fcs_flag, mba, dem, sof, crs, rxv, txr, slow;
  logic              rx_ready, req, we, ack, txv, txl, txf, busy;
  logic [ADDR_W-1:0] dsc_a, rxa, addr;
  logic [7:0]        rxd, txd;
  logic [1:0]        be;
  logic [15:0]       wd, rd;
  int                miscompares, total_checks, wr_cnt, early_rd, first_ref, i;
  logic [9:0]        exp_q[$], got_q[$];
  logic [23:0]       wb_a[$];
  logic [15:0]       wb_v[$];
  logic [7:0]        rxb[70];

  ltdb_top DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .disable_tx_fcs_flag_i(disable_tx_fcs_flag),
    .modified_backoff_enable_i(mba), .tx_demand_i(dem), .tx_desc_addr_i(dsc_a),
    .rx_buf_addr_i(rxa), .rx_sof_i(sof), .rx_crs_i(crs), .rx_valid_i(rxv), .rx_data_i(rxd),
    .rx_ready_o(rx_ready), .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr), .mem_be_o(be),
    .mem_wdata_o(wd), .mem_rdata_i(rd), .mem_ack_i(ack), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_last_o(txl), .tx_fcs_o(txf), .tx_ready_i(txr), .tx_engine_busy_o(busy));
  ltdb_host_mem host (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .slow_i(slow),
    .mem_req_i(req), .mem_we_i(we), .mem_addr_i(addr), .mem_be_i(be), .mem_wdata_i(wd),
    .mem_rdata_o(rd), .mem_ack_o(ack));

  // clock at 8 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // tx sink stalls at random
  always @(negedge ref_clk_i) txr <= ($urandom_range(3, 0) != 0);
  // collect accepted tx bytes and count bus traffic
  always @(posedge ref_clk_i) begin
    if (resetn_i && txv && txr) got_q.push_back({txf, txl, txd});
    if (resetn_i && ack && we) wr_cnt++;
    else if (resetn_i && ack && wr_cnt > 0 && wr_cnt < 70) early_rd++;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    miscompares++;
    finish_test();
  end

  function automatic int wk(input logic [23:0] a);
    return int'(a[23:1]);
  endfunction : wk
  function automatic logic [7:0] byte_at(input logic [23:0] a);
    return a[0] ? host.mem_q[wk(a)][15:8] : host.mem_q[wk(a)][7:0];
  endfunction : byte_at
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic put_byte(input logic [23:0] a, input logic [7:0] v);
    if (!host.mem_q.exists(wk(a))) host.mem_q[wk(a)] = 16'h0000;
    if (a[0]) host.mem_q[wk(a)][15:8] = v;
    else host.mem_q[wk(a)][7:0] = v;
  endtask : put_byte
  // owned descriptor at d with n random bytes; expected stream gets fcs flag ef
  task automatic put_desc(input logic [23:0] d, input int n, input logic fb, sp, ep, ef);
    logic [23:0] b;
    logic [15:0] w1;
    logic [7:0]  v;
    b = d + 24'h00_0100 + 24'($urandom_range(1, 0));
    w1 = {1'b1, 1'b0, fb, 3'b000, sp, ep, b[23:16]};
    host.mem_q[wk(d)] = b[15:0];
    host.mem_q[wk(d + 24'h00_0002)] = w1;
    host.mem_q[wk(d + 24'h00_0004)] = 16'(-n);
    wb_a.push_back(d + 24'h00_0002);
    wb_v.push_back(w1);
    for (int k = 0; k < n; k++) begin
      v = 8'($urandom);
      put_byte(b + 24'(k), v);
      exp_q.push_back({ef, ep && (k == n - 1), v});
    end
  endtask : put_desc
  task automatic wait_done(input int nw);
    for (int t = 0; t < 5000; t++) begin
      if (got_q.size() >= exp_q.size() && !busy && wr_cnt >= nw) break;
      @(negedge ref_clk_i);
    end
    repeat (20) @(negedge ref_clk_i);
  endtask : wait_done
  task automatic check_all();
    chk("tx byte count", 16'(exp_q.size()), 16'(got_q.size()));
    foreach (exp_q[k])
      if (k < got_q.size()) chk("tx byte", 16'(exp_q[k]), 16'(got_q[k]));
    foreach (wb_a[k]) chk("writeback", wb_v[k] & 16'h7fff, host.mem_q[wk(wb_a[k])]);
    exp_q.delete();
    got_q.delete();
    wb_a.delete();
    wb_v.delete();
  endtask : check_all
  task automatic poll();
    dsc_a = D0;
    dem = 1'b1;
    @(negedge ref_clk_i);
    dem = 1'b0;
    // engine leaves idle here, so busy is already up for wait_done
    @(negedge ref_clk_i);
  endtask : poll
  task automatic do_reset();
    resetn_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    resetn_i = 1'b1;
  endtask : do_reset
  // carrier in mid gap, then time from carrier drop to the first tx byte offer
  task automatic backoff(input logic m, input int lo, input int hi);
    int t;
    do_reset();
    mba = m;
    repeat (600) @(negedge ref_clk_i);
    crs = 1'b1;
    repeat (100) @(negedge ref_clk_i);
    crs = 1'b0;
    put_desc(D0, 2, 1'b0, 1'b1, 1'b1, !disable_tx_fcs_flag);
    poll();
    for (t = 1; t < 3000 && txv !== 1'b1; t++) @(negedge ref_clk_i);
    chk("ifs wait in range", 16'h0001, 16'(t >= lo && t <= hi));
    wait_done(0);
    check_all();
  endtask : backoff
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    void'($urandom(32'h3ca69977));
    {resetn_i, disable_tx_fcs_flag, mba, dem, sof, crs, rxv, slow} = '0;
    {dsc_a, rxa, rxd} = '0;
    do_reset();
    chk("rx ready after reset", 16'h0001, 16'(rx_ready));
    chk("tx valid after reset", 16'h0000, 16'(txv));
    // every fcs mode and descriptor bit setting
    for (int m = 0; m < 4; m++) begin
      disable_tx_fcs_flag = m[1];
      put_desc(D0, $urandom_range(6, 1), m[0], 1'b1, 1'b1, !m[1] || m[0]);
      poll();
      wait_done(0);
      check_all();
    end
    // chained frame: only the start descriptor decides fcs
    disable_tx_fcs_flag = 1'b1;
    for (int k = 0; k < 2; k++) begin
      put_desc(D0, 3, !k[0], 1'b1, 1'b0, !k[0]);
      put_desc(D0 + DESC_STRIDE, 2, k[0], 1'b0, 1'b1, !k[0]);
      poll();
      wait_done(0);
      check_all();
    end
    // zero length buffer
    put_desc(D0, 0, 1'b1, 1'b1, 1'b1, 1'b1);
    poll();
    wait_done(0);
    check_all();
    // receive with slow memory fills the rx fifo while a tx frame is pending
    disable_tx_fcs_flag = 1'b0;
    put_desc(D0, 40, 1'b0, 1'b1, 1'b1, 1'b1);
    foreach (rxb[k]) rxb[k] = 8'($urandom);
    slow = 1'b1;
    wr_cnt = 0;
    early_rd = 0;
    first_ref = -1;
    i = 0;
    rxa = RXA;
    sof = 1'b1;
    @(negedge ref_clk_i);
    sof = 1'b0;
    for (int t = 0; i < 70 && t < 3000; t++) begin
      rxv = 1'b1;
      rxd = rxb[i];
      if (rx_ready) i++;
      else if (first_ref < 0) first_ref = i;
      if (first_ref >= 0) slow = 1'b0;
      @(negedge ref_clk_i);
    end
    rxv = 1'b0;
    // 70 rx byte writes plus one descriptor writeback
    wait_done(71);
    chk("rx fifo refuses after", 16'h0001, 16'(first_ref >= 64));
    chk("tx reads between rx writes", 16'h0001, 16'(early_rd >= 8));
    foreach (rxb[k]) chk("rx byte in memory", 16'(rxb[k]), 16'(byte_at(RXA + 24'(k))));
    check_all();
    // standard then modified backoff
    backoff(1'b0, 1195, 1240);
    backoff(1'b1, 570, 640);
    finish_test();
  end
endmodule : tb
